// ===== line_interface_circuit_pkg.sv
// Shared constants and types for the line interface signaling pin block
package line_interface_circuit_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int DEB_STEP_US = 2000;
  localparam int RING_HALF_US = 1000;
  localparam int DEB_STEP_CYCLES = DEB_STEP_US * CLK_KHZ / 1000;
  localparam int RING_HALF_CYCLES = RING_HALF_US * CLK_KHZ / 1000;
  localparam int NUM_CH_DEF = 4;

  // ==========================================================
  // Extended register indexes and fields
  localparam logic [2:0] XR_OUT = 3'h0;
  localparam logic [2:0] XR_DATA = 3'h1;
  localparam logic [2:0] XR_DIR = 3'h2;
  localparam logic [2:0] XR_THIRD = 3'h3;
  localparam logic [2:0] XR_DEB = 3'h4;
  localparam logic [7:0] XR_RESET = 8'h00;
  localparam logic [1:0] XOP_CODE = 2'h3;
  localparam logic [3:0] DEB_OFF = 4'h0;
  localparam logic [3:0] RING_HIGH = 4'h0;
  localparam logic [3:0] RING_LOW = 4'hf;
  localparam logic [7:0] MASK8_TWO = 8'h0f;
  localparam logic [3:0] MASK4_TWO = 4'h3;

  // ==========================================================
  // Status vector: third pins, bidir pins, dedicated inputs
  localparam int STAT_W = 20;
  localparam logic [19:0] GRP12_MASK = 20'h30f0f;
  localparam logic [19:0] GRP34_MASK = 20'hcf0f0;

  typedef struct packed {
    logic [3:0] third_pin;
    logic [7:0] bidir_pin;
    logic [7:0] si_pin;
  } line_interface_circuit_stat_t;

  typedef struct packed {
    logic sw_reset;
    logic fixed_zero;
    logic rw;
    logic [1:0] code;
    logic [2:0] length_field;
  } line_interface_circuit_xop_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CMD = 2'b01,
    S_DATA = 2'b11,
    S_SKIP = 2'b10
  } line_interface_circuit_state_t;
endpackage

// ===== line_interface_circuit_tick.sv
// Free running divider that gives one-cycle tick enables
`timescale 1ns/1ns
module line_interface_circuit_tick #(
  parameter int CYCLES = line_interface_circuit_pkg::RING_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clear,
  output logic tick
);
  import line_interface_circuit_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb
  begin
    tick = (cnt == CW'(CYCLES - 1)) && !clear;
    next_cnt = (clear || tick) ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end
endmodule

// ===== line_interface_circuit_debounce.sv
// Input synchroniser and stable-interval filter for signaling inputs
`timescale 1ns/1ns
module line_interface_circuit_debounce #(
  parameter int W = line_interface_circuit_pkg::STAT_W,
  parameter int STEP_CYCLES = line_interface_circuit_pkg::DEB_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] raw,
  input wire logic [3:0] interval,
  output logic [W-1:0] status,
  output logic load,
  output logic [W-1:0] changed
);
  import line_interface_circuit_pkg::*;
  localparam int DW = $clog2(STEP_CYCLES + 1);
  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] last;
  logic [W-1:0] next_status;
  logic [DW-1:0] div;
  logic [DW-1:0] next_div;
  logic [3:0] steps;
  logic [3:0] next_steps;

  // ==========================================================
  // Stable interval
  always_comb
  begin
    next_status = status;
    next_div = div;
    next_steps = steps;
    load = 1'b0;
    changed = status ^ last;
    if (interval == DEB_OFF)
    begin
      next_status = sync2;
      next_div = '0;
      next_steps = '0;
    end
    else if (sync2 != last)
    begin
      // Any movement restarts the whole interval
      next_div = '0;
      next_steps = '0;
    end
    else if (status != last)
    begin
      if (div == DW'(STEP_CYCLES - 1))
      begin
        next_div = '0;
        next_steps = steps + 4'h1;
        if (steps + 4'h1 == interval)
        begin
          load = 1'b1;
          next_status = last;
          next_steps = '0;
        end
      end
      else
        next_div = div + DW'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      last <= '0;
      status <= '0;
      div <= '0;
      steps <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
      last <= sync2;
      status <= next_status;
      div <= next_div;
      steps <= next_steps;
    end
  end
endmodule

// ===== line_interface_circuit_sigpin.sv
// Signaling pin control: extended-operation registers, pins, debounce, ring output
`timescale 1ns/1ns
module line_interface_circuit_sigpin #(
  parameter int NUM_CH = line_interface_circuit_pkg::NUM_CH_DEF,
  parameter int DEB_STEP = line_interface_circuit_pkg::DEB_STEP_CYCLES,
  parameter int RING_HALF = line_interface_circuit_pkg::RING_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic frame_sel,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic [7:0] command_output_pin,
  input wire logic [7:0] indication_in,
  input wire logic [7:0] bidir_signal_pin_in,
  output logic [7:0] bidir_signal_pin_out,
  output logic [7:0] bidir_signal_pin_oe_n,
  input wire logic [3:0] third_pin_in,
  output logic [3:0] third_pin_out,
  output logic [3:0] third_pin_oe_n,
  output logic ring_generator_out,
  output logic irq_channels_one_two,
  output logic irq_channels_three_four
);
  import line_interface_circuit_pkg::*;
  localparam logic [7:0] M8 = (NUM_CH == 4) ? 8'hff : MASK8_TWO;
  localparam logic [3:0] M4 = (NUM_CH == 4) ? 4'hf : MASK4_TWO;

  function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] lvl);
    mix = (dir & dat) | (~dir & lvl);
  endfunction

  line_interface_circuit_state_t state;
  line_interface_circuit_state_t next_state;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic rd_mode;
  logic next_rd_mode;
  logic sw_rst;
  logic next_sw_rst;
  logic rst_all_n;
  logic [7:0] xr0;
  logic [7:0] xr_data;
  logic [7:0] xr_dir;
  logic [7:0] xr3;
  logic [7:0] xr4;
  logic [7:0] next_xr0;
  logic [7:0] next_xr_data;
  logic [7:0] next_xr_dir;
  logic [7:0] next_xr3;
  logic [7:0] next_xr4;
  logic [7:0] next_rd_byte;
  logic next_rd_valid;
  logic next_irq12;
  logic next_irq34;
  logic [3:0] ring_cnt;
  logic [3:0] next_ring_cnt;
  logic next_ring;
  logic ring_tick;
  logic ring_fixed;
  logic [7:0] third_mix;
  line_interface_circuit_xop_t cmd;
  line_interface_circuit_stat_t stat;
  logic [STAT_W-1:0] stat_vec;
  logic [STAT_W-1:0] deb_changed;
  logic [STAT_W-1:0] in_changed;
  logic deb_load;

  // Software reset acts like the pin, one cycle after its command byte
  assign rst_all_n = reset_n && !sw_rst;
  assign stat = line_interface_circuit_stat_t'(stat_vec);

  // ==========================================================
  // Timebases and input filter
  line_interface_circuit_debounce #(
    .W(STAT_W),
    .STEP_CYCLES(DEB_STEP)
  ) u_deb (
    .clk_sys(clk_sys),
    .reset_n(rst_all_n),
    .raw({third_pin_in, bidir_signal_pin_in, indication_in}),
    .interval(xr4[7:4]),
    .status(stat_vec),
    .load(deb_load),
    .changed(deb_changed)
  );

  assign ring_fixed = (xr4[3:0] == RING_HIGH) || (xr4[3:0] == RING_LOW);

  line_interface_circuit_tick #(
    .CYCLES(RING_HALF)
  ) u_ring_tick (
    .clk_sys(clk_sys),
    .reset_n(rst_all_n),
    .clear(ring_fixed),
    .tick(ring_tick)
  );

  // ==========================================================
  // Extended-operation command sequencer
  always_comb
  begin
    cmd = line_interface_circuit_xop_t'(byte_in);
    next_state = state;
    next_idx = idx;
    next_rd_mode = rd_mode;
    next_sw_rst = 1'b0;
    next_xr0 = xr0;
    next_xr_data = xr_data;
    next_xr_dir = xr_dir;
    next_xr3 = xr3;
    next_xr4 = xr4;
    next_rd_byte = rd_byte;
    next_rd_valid = 1'b0;
    next_irq12 = irq_channels_one_two;
    next_irq34 = irq_channels_three_four;
    third_mix = mix({4'h0, xr3[3:0]}, {4'h0, xr3[7:4]}, {4'h0, stat.third_pin});
    unique case (state)
      S_IDLE:
        if (frame_sel)
          next_state = S_CMD;
      S_CMD:
        if (!frame_sel)
          next_state = S_IDLE;
        else if (byte_valid)
        begin
          if (cmd.sw_reset)
          begin
            next_sw_rst = 1'b1;
            next_state = S_SKIP;
          end
          else if (cmd.code == XOP_CODE && !cmd.fixed_zero)
          begin
            next_state = S_DATA;
            next_idx = cmd.length_field;
            next_rd_mode = cmd.rw;
            if (cmd.rw)
            begin
              next_irq12 = 1'b0;
              next_irq34 = 1'b0;
            end
          end
          else
            next_state = S_SKIP;
        end
      S_DATA:
        if (!frame_sel)
          next_state = S_IDLE;
        else if (byte_valid)
        begin
          if (rd_mode)
          begin
            next_rd_valid = 1'b1;
            case (idx)
              XR_OUT: next_rd_byte = stat.si_pin & M8;
              XR_DATA: next_rd_byte = mix(xr_dir, xr_data, stat.bidir_pin) & M8;
              XR_DIR: next_rd_byte = xr_dir;
              XR_THIRD: next_rd_byte = {third_mix[3:0] & M4, xr3[3:0]};
              XR_DEB: next_rd_byte = xr4;
              default: next_rd_byte = 8'h00;
            endcase
          end
          else
          begin
            case (idx)
              XR_OUT: next_xr0 = byte_in & M8;
              XR_DATA: next_xr_data = byte_in & M8;
              XR_DIR: next_xr_dir = byte_in & M8;
              XR_THIRD: next_xr3 = byte_in & {M4, M4};
              XR_DEB: next_xr4 = byte_in;
              default: next_xr4 = xr4;
            endcase
          end
          // Highest register first, frame closes after register 0
          if (idx == 3'h0)
            next_state = S_SKIP;
          else
            next_idx = idx - 3'h1;
        end
      S_SKIP:
        if (!frame_sel)
          next_state = S_IDLE;
    endcase
    // Late set beats a read-frame clear of the same cycle
    if (deb_load && |(in_changed & GRP12_MASK))
      next_irq12 = 1'b1;
    if (deb_load && |(in_changed & GRP34_MASK))
      next_irq34 = 1'b1;
  end

  // Pins switched to output echo our own drive; only inputs interrupt
  assign in_changed = deb_changed & {~xr3[3:0], ~xr_dir, 8'hff};

  // ==========================================================
  // Ring generator
  always_comb
  begin
    next_ring = ring_generator_out;
    next_ring_cnt = ring_cnt;
    if (xr4[3:0] == RING_HIGH)
    begin
      next_ring = 1'b1;
      next_ring_cnt = 4'h0;
    end
    else if (xr4[3:0] == RING_LOW)
    begin
      next_ring = 1'b0;
      next_ring_cnt = 4'h0;
    end
    else if (ring_tick)
    begin
      // Half period of T ms gives a full period of T times 2 ms
      if (ring_cnt + 4'h1 >= xr4[3:0])
      begin
        next_ring = !ring_generator_out;
        next_ring_cnt = 4'h0;
      end
      else
        next_ring_cnt = ring_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_all_n)
    begin
      state <= S_IDLE;
      idx <= 3'h0;
      rd_mode <= 1'b0;
      xr0 <= XR_RESET;
      xr_data <= XR_RESET;
      xr_dir <= XR_RESET;
      xr3 <= XR_RESET;
      xr4 <= XR_RESET;
      rd_byte <= 8'h00;
      rd_valid <= 1'b0;
      irq_channels_one_two <= 1'b0;
      irq_channels_three_four <= 1'b0;
      ring_cnt <= 4'h0;
      ring_generator_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      rd_mode <= next_rd_mode;
      xr0 <= next_xr0;
      xr_data <= next_xr_data;
      xr_dir <= next_xr_dir;
      xr3 <= next_xr3;
      xr4 <= next_xr4;
      rd_byte <= next_rd_byte;
      rd_valid <= next_rd_valid;
      irq_channels_one_two <= next_irq12;
      irq_channels_three_four <= next_irq34;
      ring_cnt <= next_ring_cnt;
      ring_generator_out <= next_ring;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      sw_rst <= 1'b0;
    else
      sw_rst <= next_sw_rst;
  end

  // ==========================================================
  // Pin drivers
  assign command_output_pin = xr0;
  assign bidir_signal_pin_out = xr_data & xr_dir;
  assign bidir_signal_pin_oe_n = ~xr_dir;
  assign third_pin_out = xr3[7:4] & xr3[3:0];
  assign third_pin_oe_n = ~xr3[3:0];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence data_byte_s;
    state == S_DATA && frame_sel && byte_valid;
  endsequence

  sequence wr_idx_s(logic [2:0] i);
    data_byte_s ##0 (!rd_mode && idx == i);
  endsequence

  out_pin_write_a: assert property (wr_idx_s(XR_OUT) |=> command_output_pin == ($past(byte_in) & M8))
    else $error("command pins do not follow register 0 write");
  bidir_write_a: assert property (wr_idx_s(XR_DATA) |=> bidir_signal_pin_out == ($past(byte_in) & M8 & xr_dir))
    else $error("bidir output pins do not follow data write");
  dir_write_a: assert property (wr_idx_s(XR_DIR) |=> bidir_signal_pin_oe_n == ~($past(byte_in) & M8))
    else $error("bidir enables do not follow direction write");
  third_write_a: assert property (wr_idx_s(XR_THIRD) |=> third_pin_oe_n == ~($past(byte_in[3:0]) & M4))
    else $error("third pin enables do not follow write");
  bidir_read_a: assert property ((data_byte_s ##0 (rd_mode && idx == XR_DATA)) |=>
      rd_valid && rd_byte == (mix($past(xr_dir), $past(xr_data), $past(stat.bidir_pin)) & M8))
    else $error("bidir read does not return pin levels");
  upper_zero_a: assert property ((NUM_CH != 4) |-> bidir_signal_pin_oe_n[7:4] == 4'hf && command_output_pin[7:4] == 4'h0)
    else $error("two-channel variant drives upper pins");
  sw_reset_a: assert property ((state == S_CMD && frame_sel && byte_valid && byte_in[7]) |=> ##1
      (bidir_signal_pin_oe_n == 8'hff && third_pin_oe_n == 4'hf))
    else $error("software reset leaves a pin driven");
  count_down_a: assert property ((data_byte_s ##0 (idx != 3'h0)) |=> idx == $past(idx) - 3'h1)
    else $error("register index does not count down");
  irq_off_a: assert property ((xr4[7:4] == DEB_OFF) |=> !$rose(irq_channels_one_two))
    else $error("interrupt raised while debounce is off");
  irq_cause_a: assert property ($rose(irq_channels_three_four) |-> $past(deb_load) && |($past(in_changed) & GRP34_MASK))
    else $error("channel 3/4 interrupt without its input change");
  ring_high_a: assert property ((xr4[3:0] == RING_HIGH) |=> ring_generator_out)
    else $error("ring output not high for code zero");
  ring_low_a: assert property ((xr4[3:0] == RING_LOW) |=> !ring_generator_out)
    else $error("ring output not low for all-ones code");
endmodule

// ===== line_interface_circuit_line_model.sv
// Line interface circuit model that drives indication levels and resolves the shared pin wires
`timescale 1ns/1ns
module line_interface_circuit_line_model (
  input wire logic [7:0] ind_lvl,
  input wire logic [7:0] sb_lvl,
  input wire logic [3:0] tp_lvl,
  input wire logic [7:0] bidir_signal_pin_out,
  input wire logic [7:0] bidir_signal_pin_oe_n,
  input wire logic [3:0] third_pin_out,
  input wire logic [3:0] third_pin_oe_n,
  output logic [7:0] indication_in,
  output logic [7:0] bidir_signal_pin_in,
  output logic [3:0] third_pin_in
);
  // ==========================================================
  // Wire resolution
  assign indication_in = ind_lvl;
  // Line side lets go wherever the device drives, so the wire shows the device
  assign bidir_signal_pin_in = (bidir_signal_pin_oe_n & sb_lvl) | (~bidir_signal_pin_oe_n & bidir_signal_pin_out);
  assign third_pin_in = (third_pin_oe_n & tp_lvl) | (~third_pin_oe_n & third_pin_out);
endmodule

// ===== test_line_interface_circuit_signaling_pin_control.sv
// Self-checking testbench for the signaling pin block
`timescale 1ns/1ns
module test_line_interface_circuit_signaling_pin_control;
  import line_interface_circuit_pkg::*;
  localparam int DEB = 10;
  localparam int RHALF = 5;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic frame_sel = 1'b0;
  logic byte_valid = 1'b0;
  logic [7:0] byte_in = 8'h00;
  logic [7:0] rd_byte, command_output_pin, indication_in, bidir_signal_pin_in;
  logic [7:0] bidir_signal_pin_out, bidir_signal_pin_oe_n;
  logic [3:0] third_pin_in, third_pin_out, third_pin_oe_n;
  logic rd_valid, ring_generator_out, irq_channels_one_two, irq_channels_three_four;
  logic [7:0] ind_lvl = 8'h00;
  logic [7:0] sb_lvl = 8'h00;
  logic [3:0] tp_lvl = 4'h0;
  logic [7:0] wr [8];
  logic [7:0] exp_q [$];
  int bad_count = 0;
  int tests_run = 0;
  int seed = 32333;
  int n;

  always #20 clk_sys = ~clk_sys;

  line_interface_circuit_sigpin #(.NUM_CH(4), .DEB_STEP(DEB), .RING_HALF(RHALF)) i_line_interface_circuit_sigpin (
    .clk_sys(clk_sys), .reset_n(reset_n), .frame_sel(frame_sel), .byte_valid(byte_valid),
    .byte_in(byte_in), .rd_byte(rd_byte), .rd_valid(rd_valid), .command_output_pin(command_output_pin),
    .indication_in(indication_in), .bidir_signal_pin_in(bidir_signal_pin_in),
    .bidir_signal_pin_out(bidir_signal_pin_out), .bidir_signal_pin_oe_n(bidir_signal_pin_oe_n),
    .third_pin_in(third_pin_in), .third_pin_out(third_pin_out), .third_pin_oe_n(third_pin_oe_n),
    .ring_generator_out(ring_generator_out), .irq_channels_one_two(irq_channels_one_two),
    .irq_channels_three_four(irq_channels_three_four));

  line_interface_circuit_line_model i_line_interface_circuit_line_model (
    .ind_lvl(ind_lvl), .sb_lvl(sb_lvl), .tp_lvl(tp_lvl), .bidir_signal_pin_out(bidir_signal_pin_out),
    .bidir_signal_pin_oe_n(bidir_signal_pin_oe_n), .third_pin_out(third_pin_out),
    .third_pin_oe_n(third_pin_oe_n), .indication_in(indication_in),
    .bidir_signal_pin_in(bidir_signal_pin_in), .third_pin_in(third_pin_in));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons: %0d, mismatches: %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic frame(input logic rst, input logic rw, input logic [2:0] len);
    @(negedge clk_sys) frame_sel = 1'b1;
    @(negedge clk_sys) byte_valid = 1'b1;
    byte_in = {rst, 1'b0, rw, XOP_CODE, len};
    for (int i = len; i >= 0; i--)
      @(negedge clk_sys) byte_in = wr[i];
    @(negedge clk_sys) byte_valid = 1'b0;
    frame_sel = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic read_all();
    logic [7:0] d3;
    d3 = {(wr[3][7:4] & wr[3][3:0]) | (~wr[3][3:0] & tp_lvl), wr[3][3:0]};
    repeat (3) exp_q.push_back(8'h00);
    exp_q.push_back(wr[4]);
    exp_q.push_back(d3);
    exp_q.push_back(wr[2]);
    exp_q.push_back((wr[1] & wr[2]) | (~wr[2] & sb_lvl));
    exp_q.push_back(ind_lvl);
    frame(1'b0, 1'b1, 3'h7);
    check(8'(exp_q.size()), 8'h00);
  endtask

  task automatic check_pins();
    check(command_output_pin, wr[0]);
    check(bidir_signal_pin_out, wr[1] & wr[2]);
    check(bidir_signal_pin_oe_n, ~wr[2]);
    check({4'h0, third_pin_out}, {4'h0, wr[3][7:4] & wr[3][3:0]});
    check({4'h0, third_pin_oe_n}, {4'h0, ~wr[3][3:0]});
  endtask

  task automatic wait_irq(input logic grp34);
    for (n = 0; n < 60 && (grp34 ? irq_channels_three_four : irq_channels_one_two) !== 1'b1; n++)
      @(negedge clk_sys);
  endtask

  task automatic ring_toggle();
    logic r;
    r = ring_generator_out;
    for (n = 0; n < 100 && ring_generator_out === r; n++)
      @(negedge clk_sys);
  endtask

  // ==========================================================
  // Read result monitor
  always @(negedge clk_sys)
    if (rd_valid === 1'b1)
      check(rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

  // ==========================================================
  // Main sequence
  initial
  begin
    foreach (wr[i]) wr[i] = 8'h00;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    check_pins();
    check({7'h0, ring_generator_out}, 8'h01);
    read_all();
    repeat (4)
    begin
      foreach (wr[i]) wr[i] = 8'($random(seed));
      // Reserved debounce codes are never programmed
      wr[4][7:4] = 4'($unsigned($random(seed)) % 14);
      frame(1'b0, 1'b0, 3'h7);
      check_pins();
      ind_lvl = 8'($random(seed));
      sb_lvl = 8'($random(seed));
      tp_lvl = 4'($random(seed));
      repeat (160) @(negedge clk_sys);
      for (int i = 5; i < 8; i++) wr[i] = 8'h00;
      read_all();
    end
    // Debounced interrupts per channel group, all pins inputs
    foreach (wr[i]) wr[i] = 8'h00;
    wr[4] = 8'h20;
    frame(1'b0, 1'b0, 3'h4);
    repeat (160) @(negedge clk_sys);
    read_all();
    check({7'h0, irq_channels_one_two}, 8'h00);
    sb_lvl = sb_lvl ^ 8'h01;
    wait_irq(1'b0);
    check(8'(n >= 2 * DEB && n <= 2 * DEB + 8), 8'h01);
    check({7'h0, irq_channels_three_four}, 8'h00);
    repeat (10) @(negedge clk_sys);
    read_all();
    check({7'h0, irq_channels_one_two}, 8'h00);
    tp_lvl = tp_lvl ^ 4'h4;
    wait_irq(1'b1);
    check(8'(n >= 2 * DEB && n <= 2 * DEB + 8), 8'h01);
    check({7'h0, irq_channels_one_two}, 8'h00);
    repeat (10) @(negedge clk_sys);
    read_all();
    wr[4] = 8'h00;
    frame(1'b0, 1'b0, 3'h4);
    ind_lvl = ind_lvl ^ 8'h41;
    repeat (60) @(negedge clk_sys);
    check({6'h0, irq_channels_three_four, irq_channels_one_two}, 8'h00);
    read_all();
    // Ring generator half periods and the fixed low level
    for (int t = 1; t < 4; t += 2)
    begin
      wr[4] = 8'(t);
      frame(1'b0, 1'b0, 3'h4);
      ring_toggle();
      ring_toggle();
      check(8'(n), 8'(t * RHALF));
    end
    wr[4] = 8'h0f;
    frame(1'b0, 1'b0, 3'h4);
    repeat (10) @(negedge clk_sys);
    check({7'h0, ring_generator_out}, 8'h00);
    // Hardware reset, then software reset, in mid-run
    foreach (wr[i]) wr[i] = 8'($random(seed));
    wr[4][7:4] = 4'($unsigned($random(seed)) % 14);
    frame(1'b0, 1'b0, 3'h4);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    foreach (wr[i]) wr[i] = 8'h00;
    check_pins();
    check({7'h0, ring_generator_out}, 8'h01);
    wr[2] = 8'hff;
    wr[3] = 8'h0f;
    frame(1'b0, 1'b0, 3'h3);
    wr[2] = 8'h00;
    wr[3] = 8'h00;
    frame(1'b1, 1'b0, 3'h0);
    repeat (3) @(negedge clk_sys);
    check_pins();
    // A command byte with its fixed-zero bit set skips the whole frame
    wr[0] = 8'hff;
    @(negedge clk_sys) frame_sel = 1'b1;
    @(negedge clk_sys) byte_valid = 1'b1;
    byte_in = {3'b010, XOP_CODE, 3'h0};
    @(negedge clk_sys) byte_in = wr[0];
    @(negedge clk_sys) byte_valid = 1'b0;
    frame_sel = 1'b0;
    repeat (2) @(negedge clk_sys);
    wr[0] = 8'h00;
    check_pins();
    summarize();
  end

  // ==========================================================
  // Watchdog, far beyond the expected run of under 1500 cycles
  initial
  begin
    #800000;
    bad_count++;
    summarize();
  end
endmodule
